// ### rtl/dcr_fmt.sv
// result formatter: 10-bit signed value to and from the 16-bit data pair
// purely combinational; the caller registers whatever leaves the block
`timescale 1ns/100ps
module dcr_fmt (
  // value, format select and written data pair
  input wire logic [dcr_pkg::RES_W-1:0] value,
  input wire logic left_adjust_select,
  input wire logic [dcr_pkg::PAIR_W-1:0] wr_pair,
  // formatted results
  output logic [dcr_pkg::PAIR_W-1:0] pair,
  output logic [dcr_pkg::RES_W-1:0] dac_value
);
  import dcr_pkg::*;

  // pack for reads, unpack software writes for the output path
  always_comb begin
    if (left_adjust_select) begin
      pair = {value, {PAD_W{1'b0}}};
      dac_value = wr_pair[PAIR_W-1:PAD_W];
    end else begin
      pair = {{PAD_W{value[RES_W-1]}}, value};
      dac_value = wr_pair[RES_W-1:0];
    end
  end
endmodule

// ### rtl/dcr_pkg.sv
// constants, register map and state types for the converter result control
// assumes a 10 MHz core clock; every other file but the array model imports this package
package dcr_pkg;
  // result width and register pair width
  localparam int unsigned RES_W = 10;
  localparam int unsigned PAIR_W = 16;
  localparam int unsigned PAD_W = PAIR_W - RES_W;
  localparam int unsigned NUM_TIMERS = 4;
  // timing: core period and full conversion time, both in ns
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned CONV_TIME_NS = 6500;
  localparam logic [3:0] ADC_CYCLES = 4'hd;
  localparam logic [3:0] DAC_CYCLES = 4'hb;
  // converter clock must not run faster than nominal, so round the divide up
  localparam int unsigned CONV_CLK_NS = CONV_TIME_NS / 13;
  localparam int unsigned CONV_DIV_I = (CONV_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CONV_DIV = 4'(CONV_DIV_I);
  // last converter cycle before the first bit decision
  localparam logic [3:0] ADC_FIRST = 4'h3;
  localparam logic [3:0] DAC_FIRST = 4'h1;
  localparam logic [9:0] MSB_MASK = 10'h200;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INSEL = 8'h04;
  localparam logic [7:0] ADDR_DLO = 8'h08;
  localparam logic [7:0] ADDR_DHI = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h10;
  localparam logic [7:0] ADDR_MASK = 8'h14;
  // converter_control field positions
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_GO = 1;
  localparam int unsigned CTRL_LEFT_ADJUST_SELECT = 2;
  localparam int unsigned CTRL_DAC = 3;
  localparam int unsigned CTRL_REF = 4;
  localparam int unsigned CTRL_TRG = 5;
  // input select field positions
  localparam int unsigned INSEL_DIFF = 3;
  localparam int unsigned INSEL_CON = 4;
  localparam logic [7:0] INSEL_WMASK = 8'h1f;
  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] INSEL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [9:0] RES_RST = 10'h000;
  // conversion sequencer states
  typedef enum logic {ST_IDLE, ST_RUN} dcr_sar_state_t;
endpackage

// ### rtl/dcr_sar.sv
// successive approximation sequencer shared by both conversion directions
// assumes conv_tick is a one-cycle enable at the converter rate, start is
// only honoured while idle, and cmp_sync is already synchronised
`timescale 1ns/100ps
module dcr_sar (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // control
  input wire logic conv_tick,
  input wire logic start,
  input wire logic dac_mode,
  input wire logic [dcr_pkg::RES_W-1:0] dac_value,
  input wire logic cmp_sync,
  // status and array drive
  output logic busy,
  output logic done,
  output logic [dcr_pkg::RES_W-1:0] result,
  output logic [dcr_pkg::RES_W-1:0] trial,
  output logic sample
);
  import dcr_pkg::*;

  dcr_sar_state_t state_q, state_d;
  logic [3:0] cyc_q, cyc_d; // converter cycles finished
  logic mode_q, mode_d; // direction latched at start
  logic [9:0] buf_q, buf_d; // output value, offset binary
  logic [9:0] code_q, code_d; // decided bits
  logic [9:0] mask_q, mask_d; // bit under test
  logic [9:0] trial_q, trial_d;
  logic [9:0] result_q, result_d;
  logic done_q, done_d;
  logic sample_q, sample_d;
  logic [3:0] nc, first, last;
  logic keep;

  // one engine, two directions: decision source, first decision cycle, length and sampling differ
  always_comb begin
    state_d = state_q;
    cyc_d = cyc_q;
    mode_d = mode_q;
    buf_d = buf_q;
    code_d = code_q;
    mask_d = mask_q;
    trial_d = trial_q;
    result_d = result_q;
    done_d = 1'b0;
    sample_d = 1'b0;
    nc = cyc_q + 4'h1;
    first = mode_q ? DAC_FIRST : ADC_FIRST;
    last = mode_q ? DAC_CYCLES : ADC_CYCLES;
    keep = mode_q ? |(buf_q & mask_q) : cmp_sync;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_RUN;
          cyc_d = 4'h0;
          mode_d = dac_mode;
          // buffer taken in one core cycle, held for the whole conversion
          buf_d = {~dac_value[9], dac_value[8:0]};
          code_d = 10'h000;
          mask_d = MSB_MASK;
          trial_d = MSB_MASK;
        end
      end
      ST_RUN: begin
        if (conv_tick) begin
          cyc_d = nc;
          // hold capacitor tracks during the third cycle
          if (!mode_q && nc == ADC_FIRST) begin
            sample_d = 1'b1;
          end
          if (nc > first) begin
            code_d = keep ? (code_q | mask_q) : code_q;
            mask_d = mask_q >> 1;
            trial_d = code_d | mask_d;
          end
          // thirteen or eleven converter cycles, then flag and store
          if (nc == last) begin
            state_d = ST_IDLE;
            done_d = 1'b1;
            result_d = {~code_d[9], code_d[8:0]};
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cyc_q <= 4'h0;
      mode_q <= 1'b0;
      buf_q <= 10'h000;
      code_q <= 10'h000;
      mask_q <= 10'h000;
      trial_q <= 10'h000;
      result_q <= RES_RST;
      done_q <= 1'b0;
      sample_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      mode_q <= mode_d;
      buf_q <= buf_d;
      code_q <= code_d;
      mask_q <= mask_d;
      trial_q <= trial_d;
      result_q <= result_d;
      done_q <= done_d;
      sample_q <= sample_d;
    end
  end

  assign busy = (state_q == ST_RUN);
  assign done = done_q;
  assign result = result_q;
  assign trial = trial_q;
  assign sample = sample_q;

  // helper: converter ticks seen since start, independent of cyc_q
  logic [4:0] hcnt_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hcnt_q <= 5'h00;
    end else if (state_q == ST_IDLE) begin
      hcnt_q <= 5'h00;
    end else if (conv_tick) begin
      hcnt_q <= hcnt_q + 5'h01;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_begin;
    state_q == ST_IDLE && start;
  endsequence
  sequence s_armed;
    busy && trial_q == 10'h200 && code_q == 10'h000;
  endsequence

  AST_ARM: assert property (s_begin |=> s_armed)
    else $error("start did not arm the sequencer");
  AST_ADC_LEN: assert property (done_q && !mode_q |-> hcnt_q == 5'h0d)
    else $error("adc conversion length is not 13 ticks");
  AST_DAC_LEN: assert property (done_q && mode_q |-> hcnt_q == 5'h0b)
    else $error("dac conversion length is not 11 ticks");
endmodule

// ### rtl/dcr_top.sv
// converter result control: apb registers, trigger, pacing and interrupt
// assumes a 10 MHz core clock, timer overflow pulses on the same clock and
// an asynchronous comparator output from the analog array
//
// Contract
// - one mode at a time, shared sar
// - 10-bit result in two byte registers
// - results are signed two's complement
// - right adjust: sign fills upper six bits
// - left adjust: value high, six zeros
// - data readable in adc, writable in dac
// - full scale codes 01ffh/7fc0h, fe01h/8040h
// - eight single or four differential inputs
// - software single or timer started conversions
// - interrupt on conversion complete
// - conversion takes 6.5 us nominal
// - reference select sets result scale
// - go/busy starts, hardware clears at end
// - adc: 13 cycles, flag and result
// - dac: 11 cycles, flag at end
// - timer overflow starts, go/busy shows busy
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/100ps
module dcr_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // timer overflow pulses
  input wire logic [dcr_pkg::NUM_TIMERS-1:0] timer_ovf,
  // analog array
  input wire logic cmp_in,
  output logic converter_enable,
  output logic dac_mode,
  output logic ref_select,
  output logic [2:0] mux_channel,
  output logic mux_differential,
  output logic mux_connect,
  output logic [dcr_pkg::RES_W-1:0] sar_trial,
  output logic sample_hold,
  // interrupt
  output logic irq
);
  import dcr_pkg::*;

  // software visible state
  logic [7:0] ctrl_q, ctrl_d; // converter_control, go bit not stored
  logic [7:0] insel_q, insel_d; // channel, differential, connect
  logic [7:0] dlo_q, dlo_d; // dac value low byte
  logic [7:0] dhi_q, dhi_d; // dac value high byte
  logic [9:0] result_q, result_d; // last adc result
  logic done_flag_q, done_flag_d; // conversion_done_flag, sticky
  logic mask_q, mask_d;
  // bus answer
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic irq_q, irq_d;
  // pacing and synchroniser
  logic [3:0] div_q, div_d;
  logic cmp_meta_q, cmp_sync_q;
  // internal strobes
  logic acc, wr, setup;
  logic mapped;
  logic sw_go, trig_hit, start, tick;
  logic [2:0] trigger_source_select;
  logic sar_busy, sar_done;
  logic [9:0] sar_result, fmt_dac;
  logic [15:0] fmt_pair;

  // formatting is shared by reads and by dac writes
  dcr_fmt u_fmt (
    .value(result_q),
    .left_adjust_select(ctrl_q[CTRL_LEFT_ADJUST_SELECT]),
    .wr_pair({dhi_q, dlo_q}),
    .pair(fmt_pair),
    .dac_value(fmt_dac)
  );

  dcr_sar u_sar (
    .core_clk(core_clk),
    .resetn(resetn),
    .conv_tick(tick),
    .start(start),
    .dac_mode(ctrl_q[CTRL_DAC]),
    .dac_value(fmt_dac),
    .cmp_sync(cmp_sync_q),
    .busy(sar_busy),
    .done(sar_done),
    .result(sar_result),
    .trial(sar_trial),
    .sample(sample_hold)
  );

  // comparator arrives from the analog side: two flops before any use
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end else begin
      cmp_meta_q <= cmp_in;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // converter clock enable; free running while enabled
  always_comb begin
    tick = ctrl_q[CTRL_EN] && (div_q == CONV_DIV - 4'h1);
    if (!ctrl_q[CTRL_EN] || tick) begin
      div_d = 4'h0;
    end else begin
      div_d = div_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 4'h0;
    end else begin
      div_q <= div_d;
    end
  end

  // start sources; a request while busy is dropped
  always_comb begin
    trigger_source_select = ctrl_q[CTRL_TRG +: 3];
    trig_hit = 1'b0;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (trigger_source_select == 3'(i + 1) && timer_ovf[i]) begin
        trig_hit = 1'b1;
      end
    end
    sw_go = wr && paddr == ADDR_CTRL && pwdata[CTRL_GO] && pwdata[CTRL_EN];
    start = !sar_busy && (sw_go || (trig_hit && ctrl_q[CTRL_EN]));
  end

  // bus phases: answer one cycle into the access phase
  always_comb begin
    setup = psel && penable && !pready_q;
    acc = psel && penable && pready_q;
    wr = acc && pwrite;
    case (paddr)
      ADDR_CTRL, ADDR_INSEL, ADDR_DLO, ADDR_DHI, ADDR_STAT, ADDR_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // register writes, status set and clear
  always_comb begin
    ctrl_d = ctrl_q;
    insel_d = insel_q;
    dlo_d = dlo_q;
    dhi_d = dhi_q;
    mask_d = mask_q;
    result_d = result_q;
    if (wr) begin
      case (paddr)
        ADDR_CTRL: ctrl_d = pwdata[7:0] & ~(8'h01 << CTRL_GO);
        ADDR_INSEL: insel_d = pwdata[7:0] & INSEL_WMASK;
        // data pair only takes writes while driving the output
        ADDR_DLO: begin
          if (ctrl_q[CTRL_DAC]) begin
            dlo_d = pwdata[7:0];
          end
        end
        ADDR_DHI: begin
          if (ctrl_q[CTRL_DAC]) begin
            dhi_d = pwdata[7:0];
          end
        end
        ADDR_MASK: mask_d = pwdata[0];
        default: ;
      endcase
    end
    // the adc result stands until the next adc conversion ends
    if (sar_done && !ctrl_q[CTRL_DAC]) begin
      result_d = sar_result;
    end
    // a completion in the clearing cycle survives the clear
    done_flag_d = sar_done || (done_flag_q && !(wr && paddr == ADDR_STAT && pwdata[0]));
    irq_d = done_flag_q && mask_q;
  end

  // read data and answer
  always_comb begin
    prdata_d = prdata_q;
    pready_d = setup;
    pslverr_d = 1'b0;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      pslverr_d = !mapped;
      if (!pwrite) begin
        case (paddr)
          ADDR_CTRL: prdata_d = {24'h000000, ctrl_q[7:2], sar_busy, ctrl_q[0]};
          ADDR_INSEL: prdata_d = {24'h000000, insel_q};
          // in dac mode the pair is write only and reads as zero
          ADDR_DLO: begin
            if (!ctrl_q[CTRL_DAC]) begin
              prdata_d = {24'h000000, fmt_pair[7:0]};
            end
          end
          ADDR_DHI: begin
            if (!ctrl_q[CTRL_DAC]) begin
              prdata_d = {24'h000000, fmt_pair[15:8]};
            end
          end
          ADDR_STAT: prdata_d = {31'h00000000, done_flag_q};
          ADDR_MASK: prdata_d = {31'h00000000, mask_q};
          default: prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // register bank; everything resets to constants
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RST;
      insel_q <= INSEL_RST;
      dlo_q <= DATA_RST;
      dhi_q <= DATA_RST;
      result_q <= RES_RST;
      done_flag_q <= 1'b0;
      mask_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      insel_q <= insel_d;
      dlo_q <= dlo_d;
      dhi_q <= dhi_d;
      result_q <= result_d;
      done_flag_q <= done_flag_d;
      mask_q <= mask_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      irq_q <= irq_d;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign converter_enable = ctrl_q[CTRL_EN];
  assign dac_mode = ctrl_q[CTRL_DAC];
  assign ref_select = ctrl_q[CTRL_REF];
  assign mux_channel = insel_q[2:0];
  assign mux_differential = insel_q[INSEL_DIFF];
  assign mux_connect = insel_q[INSEL_CON];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_dac_read;
    setup && !pwrite && ctrl_q[CTRL_DAC] && (paddr == ADDR_DLO || paddr == ADDR_DHI);
  endsequence
  // a clear that meets no completion in the same cycle
  sequence s_flag_clear;
    wr && paddr == ADDR_STAT && pwdata[0] && !sar_done;
  endsequence
  // software poking the data pair while it holds an adc result
  sequence s_adc_data_write;
    wr && !ctrl_q[CTRL_DAC] && (paddr == ADDR_DLO || paddr == ADDR_DHI);
  endsequence

  AST_DONE_FLAG: assert property (sar_done |=> done_flag_q)
    else $error("completion did not set the flag");
  // irq follows flag and mask with one cycle of lag, both ways; mask may drop at any time
  AST_IRQ_LEVEL: assert property (done_flag_q && mask_q |=> irq_q)
    else $error("unmasked flag did not raise irq");
  AST_IRQ_LOW: assert property (!(done_flag_q && mask_q) |=> !irq_q)
    else $error("irq high without an unmasked flag");
  AST_SW_START: assert property (sw_go && !sar_busy |=> sar_busy [*2])
    else $error("software go did not start a conversion");
  AST_DONE_IDLE: assert property (sar_done |-> !sar_busy ##1 (!sar_busy || $past(start)))
    else $error("busy still set after completion");
  AST_TRIG_START: assert property (trig_hit && ctrl_q[CTRL_EN] && !sar_busy |=> sar_busy)
    else $error("timer overflow did not start a conversion");
  AST_RESULT_LOAD: assert property (sar_done && !ctrl_q[CTRL_DAC] |=> result_q == $past(sar_result))
    else $error("adc result not stored at completion");
  AST_RIGHT_ADJ: assert property (!ctrl_q[CTRL_LEFT_ADJUST_SELECT] |-> fmt_pair[15:10] == {6{result_q[9]}})
    else $error("right adjusted sign extension wrong");
  AST_LEFT_ADJ: assert property (ctrl_q[CTRL_LEFT_ADJUST_SELECT] |-> fmt_pair == {result_q, 6'h00})
    else $error("left adjusted layout wrong");
  AST_DAC_NOREAD: assert property (s_dac_read |=> pready_q && prdata_q == 32'h0000_0000)
    else $error("data pair readable in dac mode");
  AST_FLAG_CLEAR: assert property (s_flag_clear |=> !done_flag_q)
    else $error("write one did not clear the flag");
  AST_ADC_NOWRITE: assert property (s_adc_data_write |=> $stable(dlo_q) && $stable(dhi_q))
    else $error("data pair writable in adc mode");
endmodule

// ### test/dcr_array_model.sv
// analog array stand-in: sample-and-hold plus comparator against the trial
// assumes the bench sets analog_code before each conversion starts
`timescale 1ns/100ps
module dcr_array_model (
  // from the block
  input wire logic core_clk,
  input wire logic converter_enable,
  input wire logic dac_mode,
  input wire logic mux_connect,
  input wire logic sample_hold,
  input wire logic [9:0] sar_trial,
  // from the bench
  input wire logic [9:0] analog_code,
  input wire logic slow,
  // comparator out
  output logic cmp_in
);
  logic [9:0] held_q; // held input code, offset binary
  logic [9:0] trial_q; // trial seen one cycle late
  logic noise_q = 1'b0; // pattern for an idle comparator
  // sample once per adc conversion, hold for the rest
  always @(posedge core_clk) begin
    noise_q <= ~noise_q;
    trial_q <= sar_trial;
    // only a connected input reaches the hold cap
    if (sample_hold && mux_connect) begin
      held_q <= analog_code;
    end
  end
  // off or driving out: the comparator says nothing useful
  always_comb begin
    if (!converter_enable || dac_mode) begin
      cmp_in = noise_q;
    end else begin
      cmp_in = (held_q >= (slow ? trial_q : sar_trial));
    end
  end
endmodule

// ### test/dcr_top_tb.sv
// self-checking bench for the converter result control
// assumes the array model in dcr_array_model.sv and the package constants
`timescale 1ns/100ps
module dcr_top_tb;
  import dcr_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] timer_ovf = 4'h0;
  logic [9:0] analog_code = 10'h000;
  logic slow = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, cmp_in, converter_enable, dac_mode, ref_select;
  logic mux_differential, mux_connect, sample_hold, irq;
  logic [2:0] mux_channel;
  logic [9:0] sar_trial;
  int fail_count = 0;
  int check_count = 0;
  logic [31:0] rd; // last read data
  logic err; // last slave error
  int el; // cycles from start to irq
  logic [9:0] v;
  logic l, r;
  logic [7:0] hi;
  logic [15:0] exp;
  // corner codes with their printed right and left forms
  logic [9:0] cv [5] = '{10'h100, 10'h300, 10'h1ff, 10'h201, 10'h000};
  logic [15:0] rt [5] = '{16'h0100, 16'hff00, 16'h01ff, 16'hfe01, 16'h0000};
  logic [15:0] lt [5] = '{16'h4000, 16'hc000, 16'h7fc0, 16'h8040, 16'h0000};

  dcr_top i_dcr_top (.core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_ovf(timer_ovf), .cmp_in(cmp_in),
    .converter_enable(converter_enable), .dac_mode(dac_mode), .ref_select(ref_select),
    .mux_channel(mux_channel), .mux_differential(mux_differential),
    .mux_connect(mux_connect), .sar_trial(sar_trial), .sample_hold(sample_hold), .irq(irq));
  dcr_array_model i_dcr_array_model (.core_clk(core_clk),
    .converter_enable(converter_enable), .dac_mode(dac_mode), .mux_connect(mux_connect),
    .sample_hold(sample_hold), .sar_trial(sar_trial), .analog_code(analog_code),
    .slow(slow), .cmp_in(cmp_in));

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  task chk(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  // right adjust sign-extends, left adjust pads six zeros
  function automatic logic [15:0] fmt(input logic [9:0] x, input logic la);
    return la ? {x, 6'h00} : {{6{x[9]}}, x};
  endfunction

  // one apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    chk(n < 20, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // a written register shows on the pins only after this edge
    @(posedge core_clk);
  endtask

  // bounded wait for the interrupt line, elapsed cycles from t0 into el
  task wait_irq(input time t0);
    while (irq !== 1'b1 && $time - t0 < 30000) begin
      @(posedge core_clk);
    end
    el = int'(($time - t0) / 100);
  endtask

  // start by go write or timer k, check busy, timing, flag, then clear it
  task conv(input logic [7:0] ctl, input int k, input int lo, input int up);
    time t0;
    apb(1'b1, ADDR_CTRL, {24'h0, ctl});
    if (k > 0) begin
      @(posedge core_clk);
      timer_ovf <= 4'h1 << (k - 1);
      @(posedge core_clk);
      timer_ovf <= 4'h0;
    end
    t0 = $time;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd[1], 1'b1);
    wait_irq(t0);
    chk(el >= lo && el <= up, 1'b1);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, ADDR_STAT, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk({rd[0], irq}, 2'b00);
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, well beyond the few thousand cycles the tests need
  initial begin
    #3000000;
    fail_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    give_verdict;
  end

  initial begin
    void'($urandom(50447));
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    // every register reads zero after reset
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, 8'h18, 32'hff);
    chk(err, 1'b1);
    $display("test reset and map done");
    // every channel, single and differential
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, ADDR_INSEL, 32'(i) | 32'h10);
      chk({mux_connect, mux_differential, mux_channel}, 5'(i) | 5'h10);
    end
    apb(1'b1, ADDR_INSEL, 32'h10);
    apb(1'b1, ADDR_MASK, 32'h1);
    $display("test input select done");
    // corners in both adjusts, then random codes
    for (int i = 0; i < 18; i++) begin
      v = (i < 10) ? cv[i % 5] : 10'($urandom);
      l = (i < 10) ? (i >= 5) : 1'($urandom);
      r = 1'($urandom);
      slow <= 1'($urandom);
      analog_code <= v ^ MSB_MASK;
      conv({3'h0, r, 1'b0, l, 2'b11}, 0, 61, 70);
      chk({ref_select, dac_mode}, {r, 1'b0});
      apb(1'b0, ADDR_DHI, 32'h0);
      hi = rd[7:0];
      apb(1'b0, ADDR_DLO, 32'h0);
      exp = (i < 10) ? (l ? lt[i % 5] : rt[i % 5]) : fmt(v, l);
      chk({hi, rd[7:0]}, exp);
      chk(hi, exp[15:8]);
    end
    // data writes have no effect in adc mode
    apb(1'b1, ADDR_DLO, 32'h5a);
    apb(1'b0, ADDR_DLO, 32'h0);
    chk(rd[7:0], exp[7:0]);
    $display("test adc done");
    // dac: data write-only, eleven ticks
    apb(1'b1, ADDR_CTRL, 32'h09);
    chk({converter_enable, dac_mode}, 2'b11);
    apb(1'b1, ADDR_DLO, 32'h40);
    apb(1'b1, ADDR_DHI, 32'h01);
    apb(1'b0, ADDR_DLO, 32'h0);
    chk(rd, 32'h0);
    conv(8'h0b, 0, 51, 60);
    // +140h in offset binary is 340h on the array after the last decision
    chk(sar_trial, 10'h340);
    $display("test dac done");
    // each timer source; a pulse on another timer starts nothing
    for (int k = 1; k <= 4; k++) begin
      apb(1'b1, ADDR_CTRL, 32'(k << 5) | 32'h1);
      @(posedge core_clk);
      timer_ovf <= 4'h1 << (k % 4);
      @(posedge core_clk);
      timer_ovf <= 4'h0;
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk(rd[1], 1'b0);
      conv(8'(k << 5) | 8'h1, k, 61, 70);
    end
    $display("test timer trigger done");
    // mask gates irq, flag stays until cleared
    apb(1'b1, ADDR_CTRL, 32'h3);
    wait_irq($time);
    apb(1'b1, ADDR_MASK, 32'h0);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk({rd[0], irq}, 2'b10);
    apb(1'b1, ADDR_MASK, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(irq, 1'b1);
    apb(1'b1, ADDR_STAT, 32'h1);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk({rd[0], irq}, 2'b00);
    $display("test interrupt done");
    give_verdict;
  end
endmodule
